/* File: core/hpoc_decoder.sv */
// decoder end: unpacks rate groups and probe parameters from octets
// assumes octets arrive one per cycle, framing owns bits 8 and 7
//
// Functional notes
// RULE1: rate is flag bit over six low bits
// RULE2: first entry octets 2-4 carry low bits
// RULE3: flag octet bits 1-3 min max step
// RULE4: group j low bits at j*4-2 to j*4
// RULE5: probe octet 1 backoff, bit 6 reserved
// RULE6: probe octet 2 duration in 50 ms
// RULE7: zero duration means unspecified
// RULE8: all-ones duration reserved, never sent
// RULE9: probe octet 3 three-bit scrambler index
// RULE10: margin is bits 5-1 minus 10 dB
// RULE11: zero margin unspecified, 1 to 31 reserved
// RULE12: reserved codes raise error, framing bits ignored
`timescale 1ns/1ps
module hpoc_decoder
   import hpoc_pkg::*;
#(
   parameter int GROUPS = MAX_GROUPS
)(
   input  wire logic             i_clock,
   input  wire logic             i_rstn,
   hpoc_link_if.rx               link,
   output logic [GROUPS*21-1:0]  o_rates,
   output logic [GROUPS-1:0]     o_group_valid,
   output hpoc_probe_t           o_probe,
   output logic                  o_rate_done,
   output logic                  o_probe_done,
   output logic                  o_param_error
);
   typedef struct packed {
      logic [4:0]             idx;
      logic [2:0]             hi;
      logic [GROUPS*21-1:0]   rates;
      logic [GROUPS-1:0]      gval;
      hpoc_probe_t            probe;
      logic                   rdone;
      logic                   pdone;
      logic                   err;
      logic                   msg_err;
   } hpoc_dec_st_t;

   hpoc_dec_st_t st_q;
   hpoc_dec_st_t st_d;

   // only the six payload bits matter here
   function automatic logic [5:0] fld(input logic [7:0] o);
      fld = o[5:0]; // RULE12
   endfunction

   logic [5:0] f;
   int         g;
   int         pos;

   always_comb
   begin
      st_d  = st_q;
      f     = fld(link.octet);
      pos   = int'(st_q.idx) % OCT_PER_GRP;
      g     = int'(st_q.idx) / OCT_PER_GRP;
      st_d.rdone = 1'b0;
      st_d.pdone = 1'b0;
      if (link.valid)
      begin
         if (link.kind == KIND_RATE)
         begin
            if (pos == 0)
            begin
               // a new rate message forgets the groups of the last one
               if (st_q.idx == 5'h00)
                  st_d.gval = '0;
               st_d.hi = {f[STEP_BIT], f[MAX_BIT], f[MIN_BIT]}; // RULE3
               if ((f & FLAG_RSVD_MASK) != 6'h00)
                  st_d.msg_err = 1'b1; // RULE12
            end
            else if (g < GROUPS)
            begin
               // group base: octets j*4-2, j*4-1, j*4 hold min, max, step
               st_d.rates[g*21 + (3-pos)*7 +: 7] = {st_q.hi[pos-1], f}; // RULE1 RULE2 RULE4
               if (pos == 3)
                  st_d.gval[g] = 1'b1;
            end
         end
         else
         begin
            case (st_q.idx)
               5'h00:
               begin
                  st_d.probe.power_backoff = f[4:0]; // RULE5
                  if (f[FLAG_BIT])
                     st_d.msg_err = 1'b1; // RULE5
               end
               5'h01:
               begin
                  st_d.probe.duration = f; // RULE6 RULE7
                  if (f == DUR_RSVD)
                     st_d.msg_err = 1'b1; // RULE8
               end
               5'h02:
               begin
                  st_d.probe.scrambler_index_bits = f[2:0]; // RULE9
                  if ((f & SCR_RSVD_MASK) != 6'h00)
                     st_d.msg_err = 1'b1; // RULE9
               end
               5'h03:
               begin
                  st_d.probe.margin_valid = f[FLAG_BIT]; // RULE10
                  st_d.probe.margin       = f[4:0]; // RULE10
                  if (!f[FLAG_BIT] && f != MARG_UNSPEC)
                     st_d.msg_err = 1'b1; // RULE11
               end
               default:
                  st_d.msg_err = 1'b1;
            endcase
         end
         st_d.idx = st_q.idx + 5'h01;
         if (link.last)
         begin
            st_d.idx = 5'h00;
            st_d.err = st_d.msg_err;
            st_d.msg_err = 1'b0;
            if (link.kind == KIND_RATE)
               st_d.rdone = 1'b1;
            else
               st_d.pdone = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign o_rates       = st_q.rates;
   assign o_group_valid = st_q.gval;
   assign o_probe       = st_q.probe;
   assign o_rate_done   = st_q.rdone;
   assign o_probe_done  = st_q.pdone;
   assign o_param_error = st_q.err;
endmodule

/* File: core/hpoc_pkg.sv */
// package for the handshake parameter octet codec
// shared by the encoder end, the decoder end and the bench
package hpoc_pkg;
   localparam int RATE_W     = 7;
   localparam int LOW_W      = 6;
   localparam int OCT_W      = 8;
   localparam int FLD_W      = 6;
   localparam int MIN_BIT    = 0;
   localparam int MAX_BIT    = 1;
   localparam int STEP_BIT   = 2;
   localparam int FLAG_BIT   = 5;
   localparam int MAX_GROUPS = 4;
   localparam int OCT_PER_GRP = 4;
   localparam int PROBE_OCTS = 4;
   localparam logic [5:0] DUR_UNSPEC = 6'h00;
   localparam logic [5:0] DUR_RSVD   = 6'h3F;
   localparam logic [5:0] MARG_UNSPEC = 6'h00;
   localparam logic [5:0] FLAG_RSVD_MASK = 6'h38;
   localparam logic [5:0] SCR_RSVD_MASK  = 6'h38;
   localparam int DUR_UNIT_MS   = 50;
   localparam int MARG_OFFS_DB  = 10;

   typedef struct packed {
      logic [RATE_W-1:0] rmin;
      logic [RATE_W-1:0] rmax;
      logic [RATE_W-1:0] rstep;
   } hpoc_rate_t;

   typedef struct packed {
      logic [4:0] power_backoff;
      logic [5:0] duration;
      logic [2:0] scrambler_index_bits;
      logic       margin_valid;
      logic [4:0] margin;
   } hpoc_probe_t;

   typedef enum logic {KIND_RATE, KIND_PROBE} hpoc_kind_t;
endpackage

/* File: core/hpoc_link_if.sv */
// octet stream between encoder end and decoder end
// one octet per cycle when valid; last marks the final octet of a message
`timescale 1ns/1ps
interface hpoc_link_if;
   logic       valid;
   logic       last;
   logic       kind;
   logic [7:0] octet;
   modport tx (output valid, output last, output kind, output octet);
   modport rx (input valid, input last, input kind, input octet);
endinterface

/* File: core/hpoc_encoder.sv */
// encoder end: packs rate groups or probe parameters into octets
// assumes the user holds inputs stable from start until o_done
`timescale 1ns/1ps
module hpoc_encoder
   import hpoc_pkg::*;
#(
   parameter int GROUPS = MAX_GROUPS
)(
   input  wire logic             i_clock,
   input  wire logic             i_rstn,
   input  wire logic             i_start_rate,
   input  wire logic             i_start_probe,
   input  wire logic [2:0]       i_ngroups,
   input  wire logic [GROUPS*21-1:0] i_rates,
   input  wire hpoc_probe_t      i_probe,
   hpoc_link_if.tx               link,
   output logic                  o_busy,
   output logic                  o_done
);
   typedef enum logic [1:0] {S_IDLE, S_RATE, S_PROBE} hpoc_enc_state_t;
   typedef struct packed {
      hpoc_enc_state_t state;
      logic [4:0]      idx;
      logic [4:0]      total;
      logic            valid;
      logic            last;
      logic            kind;
      logic [7:0]      octet;
      logic            done;
      logic            busy;
   } hpoc_enc_st_t;

   hpoc_enc_st_t st_q;
   hpoc_enc_st_t st_d;
   logic [20:0]  r;
   logic [1:0]   pos;
   logic [5:0]   dur;

   always_comb
   begin
      st_d       = st_q;
      st_d.valid = 1'b0;
      st_d.last  = 1'b0;
      st_d.done  = 1'b0;
      r   = i_rates[(int'(st_q.idx) / OCT_PER_GRP) % GROUPS * 21 +: 21];
      pos = st_q.idx[1:0];
      // reserved all-ones duration is sent as unspecified instead
      dur = (i_probe.duration == DUR_RSVD) ? DUR_UNSPEC : i_probe.duration; // RULE8
      case (st_q.state)
         S_IDLE:
         begin
            st_d.idx = 5'h00;
            if (i_start_rate)
            begin
               st_d.state = S_RATE;
               st_d.total = {i_ngroups == 3'h0 ? 3'h1 : i_ngroups, 2'b00};
            end
            else if (i_start_probe)
               st_d.state = S_PROBE;
         end
         S_RATE:
         begin
            st_d.valid = 1'b1;
            st_d.kind  = KIND_RATE;
            case (pos)
               2'h0: st_d.octet = {5'h00, r[6], r[13], r[20]}; // RULE1 RULE3
               2'h1: st_d.octet = {2'b00, r[19:14]}; // RULE2 RULE4
               2'h2: st_d.octet = {2'b00, r[12:7]}; // RULE2 RULE4
               default: st_d.octet = {2'b00, r[5:0]}; // RULE2 RULE4
            endcase
            st_d.idx = st_q.idx + 5'h01;
            if (st_q.idx + 5'h01 == st_q.total)
            begin
               st_d.last  = 1'b1;
               st_d.done  = 1'b1;
               st_d.state = S_IDLE;
            end
         end
         S_PROBE:
         begin
            st_d.valid = 1'b1;
            st_d.kind  = KIND_PROBE;
            case (st_q.idx[1:0])
               2'h0: st_d.octet = {3'b000, i_probe.power_backoff}; // RULE5
               2'h1: st_d.octet = {2'b00, dur}; // RULE6 RULE7
               2'h2: st_d.octet = {5'h00, i_probe.scrambler_index_bits}; // RULE9
               default: st_d.octet = i_probe.margin_valid ?
                  {3'b001, i_probe.margin} : 8'h00; // RULE10 RULE11
            endcase
            st_d.idx = st_q.idx + 5'h01;
            if (st_q.idx == 5'(PROBE_OCTS - 1))
            begin
               st_d.last  = 1'b1;
               st_d.done  = 1'b1;
               st_d.state = S_IDLE;
            end
         end
         default: st_d.state = S_IDLE;
      endcase
      st_d.busy = st_d.state != S_IDLE;
   end

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign link.valid = st_q.valid;
   assign link.last  = st_q.last;
   assign link.kind  = st_q.kind;
   assign link.octet = st_q.octet;
   assign o_busy     = st_q.busy;
   assign o_done     = st_q.done;
endmodule

/* File: sim/hpoc_link_sva.sv */
// checker for the octet link between encoder and decoder
// assumes plain link signals and one clock domain
`timescale 1ns/1ps
module hpoc_link_sva (
   input wire logic       i_clock,
   input wire logic       i_rstn,
   input wire logic       valid,
   input wire logic       last,
   input wire logic       kind,
   input wire logic [7:0] octet
);
   // octet position inside the message; rate groups use the low two bits
   logic [2:0] pos_q;

   always_ff @(posedge i_clock or negedge i_rstn)
      if (!i_rstn)
         pos_q <= 3'h0;
      else if (valid)
         pos_q <= last ? 3'h0 : pos_q + 3'h1;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rstn);

   sequence s_same_kind;
      valid && $stable(kind);
   endsequence

   property p_back_to_back; valid && !last |=> s_same_kind; endproperty
   a_back_to_back: assert property (p_back_to_back) else $error("gap in message");
   property p_frame; valid |-> octet[7:6] == 2'h0; endproperty
   a_frame: assert property (p_frame) else $error("framing bits set");
   property p_flag; valid && !kind && pos_q[1:0] == 2'h0 |-> octet[5:3] == 3'h0; endproperty
   a_flag: assert property (p_flag) else $error("flag octet reserved bits");
   property p_rate_len; valid && !kind && last |-> pos_q[1:0] == 2'h3; endproperty
   a_rate_len: assert property (p_rate_len) else $error("rate group cut short");
   property p_probe_len; valid && kind && last |-> pos_q == 3'h3; endproperty
   a_probe_len: assert property (p_probe_len) else $error("probe length");
   property p_backoff; valid && kind && pos_q == 3'h0 |-> !octet[5]; endproperty
   a_backoff: assert property (p_backoff) else $error("backoff bit 6 set");
   property p_dur; valid && kind && pos_q == 3'h1 |-> octet[5:0] != 6'h3F; endproperty
   a_dur: assert property (p_dur) else $error("reserved duration sent");
   property p_scr; valid && kind && pos_q == 3'h2 |-> octet[5:3] == 3'h0; endproperty
   a_scr: assert property (p_scr) else $error("scrambler high bits set");
   property p_marg; valid && kind && pos_q == 3'h3 |-> octet[5] || octet[5:0] == 6'h00; endproperty
   a_marg: assert property (p_marg) else $error("reserved margin sent");
endmodule

/* File: sim/handshake_param_octet_codec_tb_top.sv */
// bench: encoder to decoder over one link, a second decoder fed by hand
// assumes 100 MHz clock, inputs moved 1 ns after the rising edge
`timescale 1ns/1ps
module handshake_param_octet_codec_tb_top;
   import hpoc_pkg::*;
   logic                     i_clock, i_rstn, i_start_rate, i_start_probe;
   logic [2:0]               i_ngroups;
   logic [MAX_GROUPS*21-1:0] i_rates, rates_a;
   logic [MAX_GROUPS-1:0]    gv_a;
   hpoc_probe_t              i_probe, probe_a, probe_b;
   logic                     rd_a, pd_a, err_a, rd_b, pd_b, err_b, busy, done;
   int                       fails, comparisons, done_hits;
   logic [7:0]               seen[$];
   logic [19:0]              pv[3] = '{20'hF8229, 20'h07EE0, 20'h57E3F};
   hpoc_link_if link();
   hpoc_link_if link_b();
   hpoc_encoder u_hpoc_encoder (.i_clock(i_clock), .i_rstn(i_rstn), .i_start_rate(i_start_rate),
      .i_start_probe(i_start_probe), .i_ngroups(i_ngroups), .i_rates(i_rates),
      .i_probe(i_probe), .link(link.tx), .o_busy(busy), .o_done(done));
   hpoc_decoder u_hpoc_decoder (.i_clock(i_clock), .i_rstn(i_rstn), .link(link.rx),
      .o_rates(rates_a), .o_group_valid(gv_a), .o_probe(probe_a), .o_rate_done(rd_a),
      .o_probe_done(pd_a), .o_param_error(err_a));
   hpoc_decoder u_hpoc_decoder_b (.i_clock(i_clock), .i_rstn(i_rstn), .link(link_b.rx),
      .o_rates(), .o_group_valid(), .o_probe(probe_b), .o_rate_done(rd_b),
      .o_probe_done(pd_b), .o_param_error(err_b));
   hpoc_link_sva u_hpoc_link_sva (.i_clock(i_clock), .i_rstn(i_rstn), .valid(link.valid),
      .last(link.last), .kind(link.kind), .octet(link.octet));

   initial
   begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end

   always @(posedge i_clock)
   begin
      if (link.valid === 1'b1)
         seen.push_back(link.octet);
      if (done === 1'b1 && link.last === 1'b1)
         done_hits++;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // done pulses last one cycle, so each cycle is looked at
   task automatic wait_on(input int which);
      int n;
      n = 0;
      while (((which == 0) ? rd_a : (which == 1) ? pd_a : (rd_b | pd_b)) !== 1'b1 && n < 60)
      begin
         @(posedge i_clock);
         #1;
         n++;
      end
      if (n == 60)
      begin
         fails++;
         close_out();
      end
   endtask

   task automatic start(input logic rate);
      int d0;
      d0 = done_hits;
      seen.delete();
      i_start_rate = rate;
      i_start_probe = !rate;
      @(posedge i_clock);
      #1;
      i_start_rate = 1'b0;
      i_start_probe = 1'b0;
      check(busy, 1'b1, "busy");
      wait_on(rate ? 0 : 1);
      check(done_hits, d0 + 1, "done with last");
      check(busy, 1'b0, "idle");
   endtask

   task automatic send_rate(input logic [2:0] n, input logic [MAX_GROUPS*21-1:0] r);
      logic [20:0] g;
      i_ngroups = n;
      i_rates = r;
      start(1'b1);
      check(seen.size(), n * 4, "octet count");
      for (int k = 0; k < n; k++)
      begin
         g = r[k*21+:21];
         check({gv_a[k], rates_a[k*21+:21]}, {1'b1, g}, "rate");
         check({seen[k*4], seen[k*4+1], seen[k*4+2], seen[k*4+3]}, {5'h00, g[6], g[13], g[20],
            2'h0, g[19:14], 2'h0, g[12:7], 2'h0, g[5:0]}, "rate octets");
      end
   endtask

   task automatic send_probe(input hpoc_probe_t p);
      hpoc_probe_t e;
      e = p;
      if (p.duration == 6'h3F)
         e.duration = 6'h00;
      if (!p.margin_valid)
         e.margin = 5'h00;
      i_probe = p;
      start(1'b0);
      check({seen[0], seen[1], seen[2], seen[3]}, {3'h0, e.power_backoff, 2'h0, e.duration,
         5'h00, e.scrambler_index_bits, 2'h0, e.margin_valid, e.margin}, "probe octets");
      check(probe_a, e, "probe");
      check(err_a, 1'b0, "error a");
   endtask

   // hand-fed link; released octet lines show the inverse, not the last value
   task automatic raw(input logic k, input logic [31:0] o, input logic e);
      for (int i = 3; i >= 0; i--)
      begin
         link_b.valid = 1'b1;
         link_b.kind = k;
         link_b.last = (i == 0);
         link_b.octet = o[i*8+:8];
         @(posedge i_clock);
         #1;
      end
      link_b.valid = 1'b0;
      link_b.octet = ~link_b.octet;
      wait_on(2);
      @(posedge i_clock);
      #1;
      check(err_b, e, "error b");
   endtask

   initial
   begin
      {i_rstn, i_start_rate, i_start_probe, i_ngroups, i_rates, i_probe} = '0;
      {link_b.valid, link_b.last, link_b.kind, link_b.octet} = '0;
      repeat (20) @(posedge i_clock);
      #1;
      i_rstn = 1'b1;
      send_rate(3'h4, {21'h1A5F3C, 21'h0C1B6A, 21'h155555, 21'h0AAAAA});
      send_rate(3'h1, {63'h0, 21'h1FFFC0});
      for (int i = 0; i < 3; i++)
         send_probe(pv[i]);
      raw(1'b1, 32'h25010500, 1'b1);
      raw(1'b1, 32'hC5C1C5E2, 1'b0);
      check(probe_b, {5'h05, 6'h01, 3'h5, 1'b1, 5'h02}, "probe b");
      raw(1'b1, 32'h053F0500, 1'b1);
      raw(1'b1, 32'h05010D00, 1'b1);
      raw(1'b1, 32'h05010505, 1'b1);
      raw(1'b0, 32'h08010203, 1'b1);
      raw(1'b0, 32'h07010203, 1'b0);
      close_out();
   end
endmodule
